// >>> common/clock_stop_regs.vh
`ifndef CLOCK_STOP_REGS_VH
`define CLOCK_STOP_REGS_VH
// Overview of operation
// [R01] Processor clock outputs stop while the active-low processor halt input is low, and that input is treated as asynchronous.
// [R02] The outside control logic changes either halt input only on a rising edge of the free-running bus clock.
// [R03] While one group of clocks is halted, every other clock output keeps running.
// [R04] Halted processor clocks park low and restart with a full first pulse.
// [R05] Processor clocks stop and restart within fewer than 4 processor clock periods of the halt edge.
// [R06] The bus halt input stops only the six gated bus clocks, never the free-running bus clock.
// [R07] Halted bus clocks park low and restart with a full first pulse.
// [R08] Gated bus clocks stop and restart within fewer than 2 bus clock periods of the halt edge.
// [R09] During power-up each dual-function pin is held as an input so its strap level can be sampled.
// [R10] The strap levels are captured when the supply reaches the latch threshold.
// [R11] After capture each dual-function pin becomes an output driven low until clocks start.
// [R12] Outputs start toggling when the power-up timer expires, within 3 ms.
// [R13] Straps are captured once at initial power-on and later pin levels are ignored; the code captures them again after every reset.
// [R14] An undriven dual-function pin is captured as logic one.
// [R15] Each halt input is synchronised into the clock it gates, and the gate changes only while that clock is low; the code synchronises them into mclk.

`define CPU_DIV_HALF 8'h02
`define BUS_DIV_HALF 8'h04
`define CPU_CNT_W 8
`define BUS_CNT_W 8
`define STRAP_W 5
`define STRAP_RESET 5'h1F
`define STRAP_SETTLE 2'h3
`define PU_TIME_US 3000
`define MCLK_MHZ 125
`define PU_CYCLES (`PU_TIME_US * `MCLK_MHZ)
`define CPU_OUTS 3
`define BUS_OUTS 6
`endif

// >>> rtl/clock_halt_gate.v
`timescale 1ns/1ps
// ==========================================
// Glitch-free halt gate for one clock group.
module clock_halt_gate #(
    parameter N = 1
) (
    input wire mclk,
    input wire reset,
    input wire clk_en,
    input wire clk_level,
    input wire clk_fall,
    input wire halt_n_async,
    output wire [N-1:0] clk_out,
    output wire running
);
    reg sync1_q;
    reg sync2_q;
    reg gate_q;

    // The first stage feeds only the second stage.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else
        begin
            sync1_q <= halt_n_async; // see [R01]
            sync2_q <= sync1_q; // see [R15]
        end
    end

    // The gate only changes at a falling edge, so a pulse is never cut short.
    always @(posedge mclk)
    begin
        if (reset)
            gate_q <= 1'b0;
        else if (clk_fall)
            gate_q <= sync2_q & clk_en; // see [R15] see [R04] see [R07]
    end

    assign clk_out = {N{clk_level & gate_q}}; // see [R04] see [R07]
    assign running = gate_q;
endmodule

// >>> rtl/clock_stop_and_strap_latch.v
`timescale 1ns/1ps
`include "clock_stop_regs.vh"
// ==========================================
// Clock halt and strap latch top.
module clock_stop_and_strap_latch #(
    parameter PU_CYCLES = `PU_CYCLES,
    parameter CPU_OUTS = `CPU_OUTS,
    parameter BUS_OUTS = `BUS_OUTS
) (
    input wire mclk,
    input wire reset,
    input wire cpu_halt_n,
    input wire bus_halt_n,
    input wire [`STRAP_W-1:0] strap_pin_in,
    output wire [`STRAP_W-1:0] strap_pin_out,
    output wire [`STRAP_W-1:0] strap_pin_oe,
    output wire [`STRAP_W-1:0] strap_cfg,
    output wire [CPU_OUTS-1:0] cpu_clk,
    output wire free_running_bus_clock,
    output wire [BUS_OUTS-1:0] gated_bus_clock_outputs,
    output wire clocks_started
);
    reg [`CPU_CNT_W-1:0] cpu_cnt_q;
    reg [`BUS_CNT_W-1:0] bus_cnt_q;
    reg cpu_lvl_q;
    reg bus_lvl_q;
    reg [31:0] pu_cnt_q;
    reg started_q;
    wire captured;
    wire cpu_fall;
    wire bus_fall;

    // ==========================================
    // Strap capture.
    strap_latch #(.W(`STRAP_W)) u_strap (
        .mclk(mclk),
        .reset(reset),
        .pin_in(strap_pin_in),
        .strap(strap_cfg),
        .captured(captured)
    );

    assign strap_pin_oe = {`STRAP_W{captured}}; // see [R09] see [R11]
    assign strap_pin_out = {`STRAP_W{1'b0}}; // see [R11]

    // ==========================================
    // Power-up timer.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            pu_cnt_q <= 32'h0000_0000;
            started_q <= 1'b0;
        end
        else if (captured && !started_q)
        begin
            if (pu_cnt_q >= PU_CYCLES - 1)
                started_q <= 1'b1; // see [R12]
            else
                pu_cnt_q <= pu_cnt_q + 32'h0000_0001;
        end
    end
    assign clocks_started = started_q;

    // ==========================================
    // Clock generators; each stays low until the timer expires.
    always @(posedge mclk)
    begin
        if (reset || !started_q)
        begin
            cpu_cnt_q <= 8'h00;
            bus_cnt_q <= 8'h00;
            cpu_lvl_q <= 1'b0;
            bus_lvl_q <= 1'b0;
        end
        else
        begin
            if (cpu_cnt_q == `CPU_DIV_HALF - 8'h01)
            begin
                cpu_cnt_q <= 8'h00;
                cpu_lvl_q <= ~cpu_lvl_q;
            end
            else
                cpu_cnt_q <= cpu_cnt_q + 8'h01;
            if (bus_cnt_q == `BUS_DIV_HALF - 8'h01)
            begin
                bus_cnt_q <= 8'h00;
                bus_lvl_q <= ~bus_lvl_q;
            end
            else
                bus_cnt_q <= bus_cnt_q + 8'h01;
        end
    end

    // Fall strobes mark the last mclk of a high phase.
    assign cpu_fall = cpu_lvl_q && (cpu_cnt_q == `CPU_DIV_HALF - 8'h01);
    assign bus_fall = bus_lvl_q && (bus_cnt_q == `BUS_DIV_HALF - 8'h01);

    assign free_running_bus_clock = bus_lvl_q; // see [R06] see [R03]

    // ==========================================
    // Halt gates; each group only sees its own halt input.
    clock_halt_gate #(.N(CPU_OUTS)) u_cpu_gate (
        .mclk(mclk),
        .reset(reset),
        .clk_en(started_q),
        .clk_level(cpu_lvl_q),
        .clk_fall(cpu_fall),
        .halt_n_async(cpu_halt_n),
        .clk_out(cpu_clk),
        .running()
    ); // see [R05] see [R03]

    clock_halt_gate #(.N(BUS_OUTS)) u_bus_gate (
        .mclk(mclk),
        .reset(reset),
        .clk_en(started_q),
        .clk_level(bus_lvl_q),
        .clk_fall(bus_fall),
        .halt_n_async(bus_halt_n),
        .clk_out(gated_bus_clock_outputs),
        .running()
    ); // see [R08] see [R06]
endmodule

// >>> rtl/strap_latch.v
`timescale 1ns/1ps
`include "clock_stop_regs.vh"
// ==========================================
// Captures the strap levels once after each reset.
module strap_latch #(
    parameter W = 5
) (
    input wire mclk,
    input wire reset,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] strap,
    output reg captured
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [1:0] wait_q;

    always @(posedge mclk)
    begin
        s1_q <= pin_in;
        s2_q <= s1_q;
        if (reset)
        begin
            wait_q <= 2'b00;
            captured <= 1'b0;
            strap <= `STRAP_RESET; // see [R14]
        end
        else if (!captured)
        begin
            // Three cycles let the synchroniser fill before the level is taken.
            if (wait_q == `STRAP_SETTLE)
            begin
                strap <= s2_q; // see [R10]
                captured <= 1'b1; // see [R13]
            end
            else
                wait_q <= wait_q + 2'b01;
        end
    end
endmodule

// >>> tb/clock_stop_sva.sv
`timescale 1ns/1ps
`include "clock_stop_regs.vh"
// ==========================================
// Checks on the halt gates and the strap pins.
module clock_stop_sva #(
    parameter CPU_OUTS = 3,
    parameter BUS_OUTS = 6
) (
    input wire mclk,
    input wire reset,
    input wire cpu_halt_n,
    input wire bus_halt_n,
    input wire [`STRAP_W-1:0] strap_pin_out,
    input wire [`STRAP_W-1:0] strap_pin_oe,
    input wire [`STRAP_W-1:0] strap_cfg,
    input wire [CPU_OUTS-1:0] cpu_clk,
    input wire free_running_bus_clock,
    input wire [BUS_OUTS-1:0] gated_bus_clock_outputs,
    input wire clocks_started
);
    wire fr = free_running_bus_clock;
    wire gb = gated_bus_clock_outputs[0];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    cpu_park_a: assert property (!cpu_halt_n[*8] |-> cpu_clk == 0)
        else $error("cpu clock not parked");
    bus_park_a: assert property (!bus_halt_n[*8] ##1 !bus_halt_n[*4] |-> !gb)
        else $error("bus clock not parked");
    free_run_a: assert property ($rose(fr) |=> fr[*3] ##1 !fr[*4])
        else $error("free bus clock broken");
    cpu_pulse_a: assert property ($rose(cpu_clk[0]) |=> cpu_clk[0] ##1 !cpu_clk[0])
        else $error("cpu pulse shortened");
    bus_pulse_a: assert property ($rose(gb) |=> gb[*3] ##1 !gb)
        else $error("bus pulse shortened");
    bus_phase_a: assert property (gb |-> fr)
        else $error("bus gate out of phase");
    cpu_resume_a: assert property ($rose(cpu_halt_n) |-> ##[1:15] $rose(cpu_clk[0]))
        else $error("cpu restart late");
    bus_resume_a: assert property ($rose(bus_halt_n) |-> ##[1:15] $rose(gb))
        else $error("bus restart late");
    strap_low_a: assert property (strap_pin_oe != 0 |-> strap_pin_out == 0)
        else $error("strap pin not low");
    strap_hold_a: assert property (strap_pin_oe[0] && $past(strap_pin_oe[0]) |-> $stable(strap_cfg))
        else $error("strap changed");
    idle_a: assert property (!clocks_started |-> cpu_clk == 0 && !fr)
        else $error("clock before start");
    cpu_group_a: assert property (cpu_clk == {CPU_OUTS{cpu_clk[0]}})
        else $error("cpu outputs differ");
    bus_group_a: assert property (gated_bus_clock_outputs == {BUS_OUTS{gb}})
        else $error("bus outputs differ");
    strap_out_a: assert property (clocks_started |-> strap_pin_oe == {`STRAP_W{1'b1}})
        else $error("strap pin not output");
    cpu_c: cover property ($rose(cpu_halt_n));
    bus_c: cover property ($rose(bus_halt_n));
    start_c: cover property ($rose(clocks_started));
endmodule

// >>> tb/halt_ctl_model.sv
`timescale 1ns/1ps
// ==========================================
// Power control logic that moves the halt inputs on the free-running bus clock.
module halt_ctl_model (
    input wire free_running_bus_clock,
    input wire want_cpu,
    input wire want_bus,
    output reg cpu_halt_n = 1'b1,
    output reg bus_halt_n = 1'b1
);
    always @(posedge free_running_bus_clock)
    begin
        cpu_halt_n <= !want_cpu;
        bus_halt_n <= !want_bus;
    end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "clock_stop_regs.vh"
// ==========================================
// Bench top.
module testbench;
    reg mclk = 0;
    reg reset = 1;
    reg want_cpu = 0;
    reg want_bus = 0;
    reg [4:0] dmask = 5'h0F;
    reg [4:0] dval = 5'h0A;
    wire cpu_halt_n;
    wire bus_halt_n;
    wire [4:0] pin_out;
    wire [4:0] pin_oe;
    wire [4:0] strap_cfg;
    wire [2:0] cpu_clk;
    wire fr;
    wire [5:0] gb;
    wire started;
    // Undriven pins float high through the pull-up.
    wire [4:0] pin = (pin_oe & pin_out) | (~pin_oe & ((dmask & dval) | ~dmask));
    int failures = 0;
    int checks = 0;
    int nc;
    int nb;
    int nf;
    initial forever #4 mclk = !mclk;
    clock_stop_and_strap_latch #(.PU_CYCLES(20)) dut_u (.mclk(mclk), .reset(reset),
        .cpu_halt_n(cpu_halt_n), .bus_halt_n(bus_halt_n), .strap_pin_in(pin),
        .strap_pin_out(pin_out), .strap_pin_oe(pin_oe), .strap_cfg(strap_cfg),
        .cpu_clk(cpu_clk), .free_running_bus_clock(fr), .gated_bus_clock_outputs(gb),
        .clocks_started(started));
    halt_ctl_model ctl_u (.free_running_bus_clock(fr), .want_cpu(want_cpu),
        .want_bus(want_bus), .cpu_halt_n(cpu_halt_n), .bus_halt_n(bus_halt_n));
    task stop_test;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    // Counts rising edges of each clock group over 32 cycles.
    task count;
        bit pc;
        bit pb;
        bit pf;
        nc = 0;
        nb = 0;
        nf = 0;
        @(posedge mclk);
        #1;
        pc = cpu_clk[0];
        pb = gb[0];
        pf = fr;
        repeat (32)
        begin
            @(posedge mclk);
            #1;
            nc += int'(cpu_clk[0] && !pc);
            nb += int'(gb[0] && !pb);
            nf += int'(fr && !pf);
            pc = cpu_clk[0];
            pb = gb[0];
            pf = fr;
        end
    endtask
    // A start that never comes counts as a mismatch.
    task wait_start;
        for (int i = 0; i < 200 && started !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
        end
        if (started !== 1'b1)
            failures++;
    endtask
    task strap_check;
        chk("cfg", 8'h1A, strap_cfg);
        chk("oe", 8'h1F, pin_oe);
        chk("pin low", 8'h00, pin_out);
        dmask = 5'h1F;
        dval = 5'h00;
        repeat (8) @(posedge mclk);
        #1;
        chk("cfg kept", 8'h1A, strap_cfg);
    endtask
    task halt(input bit wc, input bit wb);
        want_cpu = wc;
        want_bus = wb;
        repeat (40) @(posedge mclk);
        count();
        chk("cpu", wc ? 8'h00 : 8'h08, nc);
        chk("bus", wb ? 8'h00 : 8'h04, nb);
        chk("free", 8'h04, nf);
        want_cpu = 0;
        want_bus = 0;
        repeat (40) @(posedge mclk);
        count();
        chk("cpu on", 8'h08, nc);
        chk("bus on", 8'h04, nb);
    endtask
    // A second reset in mid-run takes the straps again.
    task reset_again;
        dmask = 5'h0F;
        dval = 5'h05;
        reset = 1;
        repeat (4) @(posedge mclk);
        #1;
        chk("oe again", 8'h00, pin_oe);
        chk("stopped", 8'h00, {cpu_clk, fr});
        reset = 0;
        wait_start();
        chk("cfg again", 8'h15, strap_cfg);
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        #1;
        chk("oe in reset", 8'h00, pin_oe);
        reset = 0;
        wait_start();
        if (started === 1'b1)
        begin
            strap_check();
            halt(1, 0);
            halt(0, 1);
            halt(1, 1);
            reset_again();
        end
        stop_test();
    end
endmodule
bind clock_stop_and_strap_latch clock_stop_sva #(.CPU_OUTS(CPU_OUTS), .BUS_OUTS(BUS_OUTS))
    chk_u (.mclk(mclk), .reset(reset), .cpu_halt_n(cpu_halt_n), .bus_halt_n(bus_halt_n),
    .strap_pin_out(strap_pin_out), .strap_pin_oe(strap_pin_oe), .strap_cfg(strap_cfg),
    .cpu_clk(cpu_clk), .free_running_bus_clock(free_running_bus_clock),
    .gated_bus_clock_outputs(gated_bus_clock_outputs), .clocks_started(clocks_started));
